// >>> design/emf_defs.svh
// Constants for the emergency telegram framer: register map, reset values,
// telegram byte codes and cause codes.
// Assumes inclusion by its bare name from the framer module and the bench.
`ifndef EMF_DEFS_SVH
`define EMF_DEFS_SVH

// Register byte offsets
`define EMF_OFS_CTRL        8'h00
`define EMF_OFS_STATUS      8'h04
`define EMF_OFS_ACTIVE      8'h08
`define EMF_OFS_COUNT       8'h0c

// Control register fields and reset value
`define EMF_CTRL_EN_BIT     0
`define EMF_CTRL_NODE_LSB   8
`define EMF_CTRL_NODE_MSB   14
`define EMF_CTRL_RESET      32'h0000_0001

// Status register fields
`define EMF_STAT_BUSY_BIT   0
`define EMF_STAT_PEND_BIT   1
`define EMF_STAT_BOFF_BIT   2
`define EMF_STAT_CAUSE_LSB  8

// Identifier and length
`define EMF_ID_BASE         11'h080
`define EMF_DLC             4'h8

// Error code low and high bytes and error register values
`define EMF_EC_LOW          8'h00
`define EMF_EC_DEVICE       8'h50
`define EMF_EC_COMM         8'h81
`define EMF_EC_RESET        8'h00
`define EMF_ERROR_REGISTER_BYTE_DEVICE     8'h81
`define EMF_ERROR_REGISTER_BYTE_COMM       8'h91

// Device fault bits that exist (0x01, 0x02, 0x04, 0x10, 0x80)
`define EMF_DEV_MASK        8'h97

// Communication bit positions
`define EMF_CB_GUARD        3'd0
`define EMF_CB_SYNC         3'd1
`define EMF_CB_PDOLEN       3'd2
`define EMF_CB_EVTMR        3'd3
`define EMF_CB_RXOVR        3'd4
`define EMF_CB_TXOVR        3'd5
`define EMF_CB_BUSOFF       3'd6
`define EMF_CB_WARN         3'd7

// Cause codes
`define EMF_CC_WARN         8'h01
`define EMF_CC_RXOVR        8'h03
`define EMF_CC_TXOVR        8'h04
`define EMF_CC_PDOLEN       8'h06
`define EMF_CC_SYNC         8'h07
`define EMF_CC_GUARD        8'h08
`define EMF_CC_HWCFG        8'h09
`define EMF_CC_EVTMR        8'h0a
`define EMF_CC_UNSUP        8'h0c
`define EMF_CC_NVMEM        8'h0e
`define EMF_CC_EXTBUS       8'h0f
`define EMF_CC_TERM         8'h10
`define EMF_CC_BUSOFF_END   8'h40

`endif

// >>> design/emf_pkg.sv
// Types for the emergency telegram framer.
// Assumes emf_defs.svh holds the numeric constants.
package emf_pkg;

   typedef enum logic {
      st_idle,
      st_send
   } emf_state_t;

endpackage : emf_pkg

// >>> design/emf_framer.sv
// Emergency telegram framer: watches fault condition levels, queues one
// telegram per change except entering bus-off, and hands 8-byte frames to a CAN transmit port.
// Assumes a CAN controller that takes a frame when tx_valid and tx_ready
// are both high, and fault inputs synchronous to core_clk.
`timescale 1ns/1ns
`include "emf_defs.svh"

// Notes on behaviour
// - Telegram is eight bytes: code, register, two bit fields, cause, two info.
// - Identifier is 0x80 plus the node address.
// - First data byte, low error code byte, is always zero.
// - High error code byte: 0x50 device, 0x81 communication, 0x00 reset.
// - Error register 0x81 for device faults, 0x91 for communication faults.
// - Communication bits 0x01 guarding late, 0x02 sync late.
// - Communication bits 0x04 wrong data length, 0x08 inbound event timer missed.
// - Communication bits 0x10 rx overrun, 0x20 tx overrun, 0x40 bus-off, 0x80 warning.
// - Device bits 0x01 terminal, 0x02 extension bus, 0x04 memory, 0x10, 0x80.
// - Cause byte names the event that triggered this telegram.
// - On a cleared error send code 0x0000 with the cleared cause.
// - Both bit fields show every condition still active.
// - When no error remains, send a telegram of all zeros.
// - Cause 0x01 for crossing the warning limit.
// - No telegram during bus-off; cause 0x40 once bus-off ends.
// - Causes 0x03 and 0x04 for queue overruns losing messages.
// - Cause 0x06 carries expected then actual data length in info bytes.
// - Causes 0x07 sync, 0x08 guarding or heartbeat, 0x0A event timer.
module emf_framer
   import emf_pkg::*;
(
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        nrst,
   // Register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Fault conditions and diagnostics
   input  wire logic [7:0]  comm_fault_in,
   input  wire logic [7:0]  device_fault_in,
   input  wire logic [7:0]  pdo_len_expected,
   input  wire logic [7:0]  pdo_len_actual,
   input  wire logic [7:0]  term_info0,
   input  wire logic [7:0]  term_info1,
   // CAN transmit port
   input  wire logic        tx_ready,
   output logic             tx_valid,
   output logic      [10:0] tx_id,
   output logic      [3:0]  tx_dlc,
   output logic      [63:0] tx_data
);

   ////////////////////////////////////////////////////////////////////////////
   // State

   emf_state_t  state_q;
   emf_state_t  state_d;
   logic [31:0] ctrl_q;
   logic [15:0] prev_q;
   logic [15:0] set_pend_q;
   logic [15:0] set_pend_d;
   logic [15:0] clr_pend_q;
   logic [15:0] clr_pend_d;
   logic [7:0]  last_cause_q;
   logic [15:0] sent_cnt_q;
   logic [31:0] rdata_q;
   logic        tx_valid_q;
   logic [10:0] tx_id_q;
   logic [63:0] tx_data_q;

   ////////////////////////////////////////////////////////////////////////////
   // Change detection

   wire  [15:0] cond = {device_fault_in & `EMF_DEV_MASK, comm_fault_in};
   wire         bus_off = comm_fault_in[`EMF_CB_BUSOFF];
   logic [15:0] rise;
   logic [15:0] fall;

   genvar gi;
   generate
      for (gi = 0; gi < 16; gi = gi + 1) begin : g_chg
         if (gi == 6) begin : g_boff
            // Entering bus-off cannot be reported on the bus
            assign rise[gi] = 1'b0;
         end else begin : g_norm
            assign rise[gi] = cond[gi] & ~prev_q[gi];
         end
         assign fall[gi] = ~cond[gi] & prev_q[gi];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Selection of the next event: sets first, lowest bit first

   function automatic logic [5:0] pick(input logic [31:0] cand);
      logic [5:0] res;
      res = 6'h00;
      for (int i = 31; i >= 0; i--) begin
         if (cand[i]) begin
            res = {1'b1, i[4:0]};
         end
      end
      return res;
   endfunction : pick

   function automatic logic [7:0] cause_of(input logic [3:0] bit_idx,
                                           input logic       is_clr);
      logic [7:0] cc;
      cc = 8'h00;
      case (bit_idx)
         4'd0:    cc = `EMF_CC_GUARD;
         4'd1:    cc = `EMF_CC_SYNC;
         4'd2:    cc = `EMF_CC_PDOLEN;
         4'd3:    cc = `EMF_CC_EVTMR;
         4'd4:    cc = `EMF_CC_RXOVR;
         4'd5:    cc = `EMF_CC_TXOVR;
         4'd6:    cc = is_clr ? `EMF_CC_BUSOFF_END : 8'h00;
         4'd7:    cc = `EMF_CC_WARN;
         4'd8:    cc = `EMF_CC_TERM;
         4'd9:    cc = `EMF_CC_EXTBUS;
         4'd10:   cc = `EMF_CC_NVMEM;
         4'd12:   cc = `EMF_CC_UNSUP;
         4'd15:   cc = `EMF_CC_HWCFG;
         default: cc = 8'h00;
      endcase
      return cc;
   endfunction : cause_of

   wire  [5:0]  sel      = pick({clr_pend_q, set_pend_q});
   wire         found    = sel[5];
   wire         is_clr   = sel[4];
   wire  [3:0]  bit_idx  = sel[3:0];
   wire         is_dev   = sel[3];
   wire         enable   = ctrl_q[`EMF_CTRL_EN_BIT];
   wire  [6:0]  node_id  = ctrl_q[`EMF_CTRL_NODE_MSB:`EMF_CTRL_NODE_LSB];

   // Hold telegrams while bus-off; changes during bus-off are queued meanwhile
   wire         go = (state_q == st_idle) & enable & ~bus_off & found;
   wire         taken = (state_q == st_send) & tx_ready;

   ////////////////////////////////////////////////////////////////////////////
   // Telegram assembly

   wire         any_comm  = |cond[7:0];
   wire         any_dev   = |cond[15:8];
   wire         all_clear = is_clr & ~any_comm & ~any_dev;

   wire  [7:0]  ec_high = is_clr ? `EMF_EC_RESET :
                          (is_dev ? `EMF_EC_DEVICE : `EMF_EC_COMM);
   wire  [7:0]  error_register_byte    = any_comm ? `EMF_ERROR_REGISTER_BYTE_COMM :
                          (any_dev ? `EMF_ERROR_REGISTER_BYTE_DEVICE : 8'h00);
   wire  [7:0]  cause   = cause_of(bit_idx, is_clr);
   wire         pdo_rep = ~is_clr & (bit_idx == {1'b0, `EMF_CB_PDOLEN});
   wire  [7:0]  info0   = pdo_rep ? pdo_len_expected :
                          (cond[8] ? term_info0 : 8'h00);
   wire  [7:0]  info1   = pdo_rep ? pdo_len_actual :
                          (cond[8] ? term_info1 : 8'h00);

   // Byte 0 goes out first and sits in the low lane
   wire  [63:0] frame = all_clear ? 64'h0 :
                        {info1, info0, cause, cond[15:8], cond[7:0],
                         error_register_byte, ec_high, `EMF_EC_LOW};

   wire  [10:0] frame_id = `EMF_ID_BASE + {4'h0, node_id};

   ////////////////////////////////////////////////////////////////////////////
   // Pending events: a change in the same cycle as a take is kept

   wire  [15:0] take_mask = go ? (16'h0001 << bit_idx) : 16'h0000;

   assign set_pend_d = (set_pend_q & ~(is_clr ? 16'h0000 : take_mask)) | rise;
   assign clr_pend_d = (clr_pend_q & ~(is_clr ? take_mask : 16'h0000)) | fall;

   always_comb begin
      state_d = state_q;
      case (state_q)
         st_idle: begin
            if (go) begin
               state_d = st_send;
            end
         end
         st_send: begin
            if (tx_ready) begin
               state_d = st_idle;
            end
         end
         default: state_d = st_idle;
      endcase
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q    <= st_idle;
         prev_q     <= 16'h0000;
         set_pend_q <= 16'h0000;
         clr_pend_q <= 16'h0000;
      end else begin
         state_q    <= state_d;
         prev_q     <= cond;
         set_pend_q <= set_pend_d;
         clr_pend_q <= clr_pend_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmit port registers

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         tx_valid_q   <= 1'b0;
         tx_id_q      <= 11'h000;
         tx_data_q    <= 64'h0;
         last_cause_q <= 8'h00;
      end else if (go) begin
         tx_valid_q   <= 1'b1;
         tx_id_q      <= frame_id;
         tx_data_q    <= frame;
         last_cause_q <= all_clear ? 8'h00 : cause;
      end else if (taken) begin
         tx_valid_q   <= 1'b0;
      end
   end

   assign tx_valid = tx_valid_q;
   assign tx_id    = tx_id_q;
   assign tx_dlc   = `EMF_DLC;
   assign tx_data  = tx_data_q;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sent_cnt_q <= 16'h0000;
      end else if (taken) begin
         sent_cnt_q <= sent_cnt_q + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port

   wire         hit_ctrl   = (reg_addr == `EMF_OFS_CTRL);
   wire         hit_status = (reg_addr == `EMF_OFS_STATUS);
   wire         hit_active = (reg_addr == `EMF_OFS_ACTIVE);
   wire         hit_count  = (reg_addr == `EMF_OFS_COUNT);

   wire  [31:0] status_word = {16'h0000, last_cause_q, 5'h00, bus_off,
                               |{set_pend_q, clr_pend_q}, tx_valid_q};
   wire  [31:0] ctrl_mask   = 32'h0000_7f01;

   wire  [31:0] rd_mux = hit_ctrl   ? ctrl_q :
                         hit_status ? status_word :
                         hit_active ? {16'h0000, cond} :
                         hit_count  ? {16'h0000, sent_cnt_q} :
                         32'h0000_0000;

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_q <= `EMF_CTRL_RESET;
      end else if (reg_wr && hit_ctrl) begin
         ctrl_q <= reg_wdata & ctrl_mask;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdata_q <= 32'h0000_0000;
      end else if (reg_rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : emf_framer

// >>> testbench/emf_framer_asserts.sv
// Checker for the emergency telegram framer, bound to its top module.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/1ns
module emf_framer_asserts (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        nrst,
   // Register port
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   // Conditions and frame port
   input wire logic [7:0]  comm_fault_in,
   input wire logic [7:0]  device_fault_in,
   input wire logic        tx_ready,
   input wire logic        tx_valid,
   input wire logic [10:0] tx_id,
   input wire logic [3:0]  tx_dlc,
   input wire logic [63:0] tx_data
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   sequence taken_s;
      tx_valid && tx_ready;
   endsequence
   sequence offer_s;
      $rose(tx_valid);
   endsequence
   dlc_eight_a: assert property (tx_valid |-> tx_dlc == 4'h8)
      else $error("length code not eight");
   low_zero_a: assert property (tx_valid |-> tx_data[7:0] == 8'h00)
      else $error("first byte not zero");
   id_base_a: assert property (tx_valid |-> tx_id[10:7] == 4'h1)
      else $error("identifier outside base range");
   code_set_a: assert property (tx_valid |-> tx_data[15:8] inside {8'h00, 8'h50, 8'h81})
      else $error("bad error code byte");
   error_register_byte_val_a: assert property (tx_valid |-> tx_data[23:16] == ((tx_data[31:24] != 8'h00) ?
      8'h91 : (tx_data[39:32] != 8'h00) ? 8'h81 : 8'h00)) else $error("bad error register");
   frame_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
      && $stable(tx_id)) else $error("frame changed before acceptance");
   one_gap_a: assert property (taken_s |=> !tx_valid)
      else $error("no idle cycle after acceptance");
   busoff_quiet_a: assert property (offer_s |-> !$past(comm_fault_in[6]))
      else $error("frame offered during bus-off");
   fields_live_a: assert property (offer_s |-> tx_data[39:24] ==
      {$past(device_fault_in) & 8'h97, $past(comm_fault_in)}) else $error("bit fields stale");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside its cycle");
endmodule : emf_framer_asserts
bind emf_framer emf_framer_asserts emf_framer_asserts_inst (.core_clk(core_clk), .nrst(nrst),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comm_fault_in(comm_fault_in),
   .device_fault_in(device_fault_in), .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_id(tx_id),
   .tx_dlc(tx_dlc), .tx_data(tx_data));

// >>> testbench/emf_can_model.sv
// CAN controller model that takes emergency frames and keeps the last one.
// Assumes a valid/ready handshake in the core_clk domain.
`timescale 1ns/1ns
module emf_can_model (
   // Clock and reset
   input wire logic        core_clk,
   input wire logic        nrst,
   // Frame port
   input wire logic        tx_valid,
   input wire logic [10:0] tx_id,
   input wire logic [3:0]  tx_dlc,
   input wire logic [63:0] tx_data,
   output logic            tx_ready,
   // Bench side
   input wire logic        slow,
   output logic [15:0]     got_cnt,
   output logic [78:0]     got_frame
);
   logic ready_q;
   assign tx_ready = ready_q;
   // Slow mode stalls every other cycle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ready_q <= 1'b0;
         got_cnt <= '0;
         got_frame <= '0;
      end else begin
         ready_q <= slow ? ~ready_q : 1'b1;
         if (tx_valid && ready_q) begin
            got_cnt <= got_cnt + 16'h1;
            got_frame <= {tx_dlc, tx_id, tx_data};
         end
      end
   end
endmodule : emf_can_model

// >>> testbench/emf_framer_tb_top.sv
// Bench for the emergency telegram framer against a CAN controller model.
// Assumes the framer, its checker and the model are compiled before it.
`timescale 1ns/1ns
`include "emf_defs.svh"
module emf_framer_tb_top
   import emf_pkg::*;
;
   logic core_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
   logic tx_ready, tx_valid;
   logic [7:0] reg_addr = '0, comm = '0, dev = '0;
   logic [31:0] reg_wdata = '0, reg_rdata;
   logic [10:0] tx_id;
   logic [3:0] tx_dlc;
   logic [63:0] tx_data;
   logic [15:0] got_cnt, seen = '0;
   logic [78:0] got_frame;
   int fails = 0, comparisons = 0, nframes = 0;
   initial forever #10 core_clk = ~core_clk;
   emf_framer emf_framer_inst (.core_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .comm_fault_in(comm), .device_fault_in(dev), .pdo_len_expected(8'h05),
      .pdo_len_actual(8'h02), .term_info0(8'h0a), .term_info1(8'h82), .tx_ready, .tx_valid,
      .tx_id, .tx_dlc, .tx_data);
   emf_can_model emf_can_model_inst (.core_clk, .nrst, .tx_valid, .tx_id, .tx_dlc, .tx_data,
      .tx_ready, .slow, .got_cnt, .got_frame);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [78:0] exp, input logic [78:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic frame(input logic [10:0] id, input logic [63:0] d);
      int n = 0;
      while (got_cnt === seen && n < 60) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk("frame arrival", 79'(seen + 16'h1), 79'(got_cnt));
      seen = got_cnt;
      nframes++;
      chk("frame", {`EMF_DLC, id, d}, got_frame);
   endtask : frame
   task automatic none;
      repeat (6) @(posedge core_clk);
      #1;
      chk("frame count", 79'(seen), 79'(got_cnt));
   endtask : none
   task automatic drive(input logic [7:0] c, input logic [7:0] v);
      @(posedge core_clk);
      comm <= c;
      dev <= v;
   endtask : drive
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_check(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("register", 79'(exp), 79'(reg_rdata));
   endtask : reg_check
   ////////////////////////////////////////////////////////////////////////////////
   task automatic test_example;
      drive(8'h80, 8'h00);
      frame(11'h080, 64'h0000_0100_8091_8100);
      drive(8'h80, 8'h01);
      frame(11'h080, 64'h820a_1001_8091_5000);
      drive(8'h00, 8'h01);
      frame(11'h080, 64'h820a_0101_0081_0000);
      drive(8'h00, 8'h00);
      frame(11'h080, 64'h0);
      $display("test example done");
   endtask : test_example
   task automatic test_codes;
      logic [15:0] m [12] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010, 16'h0020,
         16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h1000, 16'h8000};
      logic [7:0] cc [12] = '{8'h08, 8'h07, 8'h06, 8'h0a, 8'h03, 8'h04, 8'h01, 8'h10, 8'h0f,
         8'h0e, 8'h0c, 8'h09};
      logic [15:0] inf;
      logic [15:0] hdr;
      for (int i = 0; i < 12; i++) begin
         slow <= (i > 6);
         drive(m[i][7:0], m[i][15:8]);
         inf = (i == 2) ? 16'h0205 : (i == 7) ? 16'h820a : 16'h0000;
         hdr = (i < 7) ? 16'h9181 : 16'h8150;
         frame(11'h080, {inf, cc[i], m[i], hdr, 8'h00});
         drive(8'h00, 8'h00);
         frame(11'h080, 64'h0);
      end
      slow <= 1'b0;
      $display("test codes done");
   endtask : test_codes
   task automatic test_busoff;
      drive(8'h40, 8'h00);
      none();
      drive(8'hc0, 8'h00);
      none();
      reg_check(`EMF_OFS_STATUS, 32'h0000_0006);
      drive(8'h80, 8'h00);
      frame(11'h080, 64'h0000_0100_8091_8100);
      frame(11'h080, 64'h0000_4000_8091_0000);
      drive(8'h00, 8'h00);
      frame(11'h080, 64'h0);
      $display("test busoff done");
   endtask : test_busoff
   task automatic test_regs;
      reg_check(`EMF_OFS_CTRL, `EMF_CTRL_RESET);
      reg_write(`EMF_OFS_CTRL, 32'h0000_0500);
      reg_check(`EMF_OFS_CTRL, 32'h0000_0500);
      reg_check(8'h20, 32'h0);
      drive(8'h01, 8'h00);
      none();
      reg_check(`EMF_OFS_ACTIVE, 32'h0000_0001);
      reg_write(`EMF_OFS_CTRL, 32'h0000_0501);
      frame(11'h085, 64'h0000_0800_0191_8100);
      reg_check(`EMF_OFS_STATUS, 32'h0000_0800);
      drive(8'h00, 8'h00);
      frame(11'h085, 64'h0);
      reg_check(`EMF_OFS_COUNT, {16'h0, nframes[15:0]});
      $display("test regs done");
   endtask : test_regs
   task automatic stop_test;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      test_example();
      test_codes();
      test_busoff();
      test_regs();
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      stop_test();
   end
endmodule : emf_framer_tb_top
